/* File: logic/nbx_pkg.sv */
package nbx_pkg;
    // host clock
    localparam int CLK_PERIOD_NS = 4;
    // number of expanders on the shared nibble bus, one select each
    localparam int NUM_UNITS = 2;
    // command nibble field positions
    localparam int PORT_LSB = 0;
    localparam int OP_LSB = 2;
    // operation codes
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_DIRECT_WRITE = 2'h1;
    localparam logic [1:0] OP_OR_WRITE = 2'h2;
    localparam logic [1:0] OP_AND_WRITE = 2'h3;
    // pin timing in ns
    localparam int T_CODE_SETUP_NS = 100;
    localparam int T_CODE_HOLD_NS = 60;
    localparam int T_STROBE_LOW_NS = 700;
    localparam int T_DATA_HOLD_NS = 20;
    localparam int T_FLOAT_NS = 150;
    // timing in cycles, least times rounded up
    localparam logic [7:0] CODE_SETUP_CYC =
        8'((T_CODE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CODE_HOLD_CYC =
        8'((T_CODE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] STROBE_LOW_CYC =
        8'((T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] DATA_HOLD_CYC =
        8'((T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] FLOAT_CYC =
        8'((T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // reset values
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    localparam logic [1:0] SEL_RST = 2'h3;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] STALE_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_CMD_HOLD,
        ST_LOW,
        ST_DATA_HOLD,
        ST_RECOVER
    } nbx_state_t;
endpackage

/* File: logic/nbx_pin_if.sv */
`timescale 1ns/100ps
interface nbx_pin_if;
    logic [3:0] bus_out;
    logic bus_oe;
    logic strobe;
    logic [1:0] sel_n;
    logic [3:0] bus_sync;
    modport ctl (
        output bus_out,
        output bus_oe,
        output strobe,
        output sel_n,
        input bus_sync
    );
    modport pin (
        input bus_out,
        input bus_oe,
        input strobe,
        input sel_n,
        output bus_sync
    );
endinterface

/* File: logic/nbx_pin_stage.sv */
`timescale 1ns/100ps
module nbx_pin_stage (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // controller side
    nbx_pin_if.pin pif,
    // pins
    input wire logic [3:0] nib_in,
    output logic [3:0] nib_out,
    output logic nib_oe,
    output logic transfer_strobe,
    output logic [1:0] unit_sel_n
);
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;

    // pin drivers, registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nib_out <= nbx_pkg::NIBBLE_RST;
            nib_oe <= 1'b0;
            transfer_strobe <= 1'b1;
            unit_sel_n <= nbx_pkg::SEL_RST;
        end else begin
            nib_out <= pif.bus_out;
            nib_oe <= pif.bus_oe;
            transfer_strobe <= pif.strobe;
            unit_sel_n <= pif.sel_n;
        end
    end

    // two-stage synchroniser on the nibble bus
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= nbx_pkg::NIBBLE_RST;
            sync2_ff <= nbx_pkg::NIBBLE_RST;
        end else begin
            sync1_ff <= nib_in;
            sync2_ff <= sync1_ff;
        end
    end

    assign pif.bus_sync = sync2_ff;
endmodule // nbx_pin_stage

/* File: logic/nbx_host.sv */
`timescale 1ns/100ps
// Function
// RULE1 - expander offers four 4-bit ports, addressed as ports 4 to 7
// RULE2 - each transaction is exactly two nibbles: command then data
// RULE3 - command nibble valid at strobe fall, data nibble at strobe rise
// RULE4 - command bits 1:0 pick port, bits 3:2 pick operation
// RULE5 - at power-up expander floats ports and listens on nibble bus
// RULE6 - expander leaves power-on state at first strobe fall
// RULE7 - expander latches operation and port at strobe fall
// RULE8 - direct write replaces the port latch
// RULE9 - OR-write merges data into the port latch with OR
// RULE10 - AND-write merges data into the port latch with AND
// RULE11 - write data taken at strobe rise, then latched and driven
// RULE12 - port latch holds until next write to that port
// RULE13 - read floats selected port drivers at once
// RULE14 - during read expander drives port pins onto nibble bus before rise
// RULE15 - strobe rise ends read, port floats, nibble bus back to input
// RULE16 - host treats first read after a write to that port as stale
// RULE17 - each expander on the shared bus gets its own select line
// RULE18 - deselected expander ignores strobe edges
// RULE19 - deselected expander leaves the nibble bus undriven
// RULE20 - host holds select low and stable across both strobe edges
module nbx_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_unit,
    input wire logic [1:0] cmd_port,
    input wire logic [1:0] cmd_op,
    input wire logic [3:0] cmd_data,
    // read answer
    output logic rsp_valid,
    output logic [3:0] rsp_data,
    output logic rsp_stale,
    // expander pins
    input wire logic [3:0] nib_in,
    output logic [3:0] nib_out,
    output logic nib_oe,
    output logic transfer_strobe,
    output logic [1:0] unit_sel_n
);
    nbx_pin_if pif ();

    nbx_pkg::nbx_state_t state_ff;
    nbx_pkg::nbx_state_t nxt_state;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic unit_ff;
    logic [1:0] port_ff;
    logic [1:0] op_ff;
    logic [3:0] data_ff;
    logic [7:0] stale_ff;
    logic [2:0] slot;
    logic is_read;
    logic cnt_done;

    assign is_read = (op_ff == nbx_pkg::OP_READ);
    assign cnt_done = (cnt_ff == 8'h01);
    assign slot = {unit_ff, port_ff};

    nbx_pin_stage u_pin (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pif(pif),
        .nib_in(nib_in),
        .nib_out(nib_out),
        .nib_oe(nib_oe),
        .transfer_strobe(transfer_strobe),
        .unit_sel_n(unit_sel_n)
    );

    // sequencer: setup, fall, low phase, rise, float recovery
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff - 8'h01;
        case (state_ff)
            nbx_pkg::ST_IDLE: begin
                nxt_cnt = cnt_ff;
                if (cmd_valid) begin
                    nxt_state = nbx_pkg::ST_SETUP;
                    nxt_cnt = nbx_pkg::CODE_SETUP_CYC;
                end
            end
            nbx_pkg::ST_SETUP: begin
                if (cnt_done) begin
                    nxt_state = nbx_pkg::ST_CMD_HOLD; // [RULE3]
                    nxt_cnt = nbx_pkg::CODE_HOLD_CYC;
                end
            end
            nbx_pkg::ST_CMD_HOLD: begin
                if (cnt_done) begin
                    nxt_state = nbx_pkg::ST_LOW;
                    nxt_cnt = nbx_pkg::STROBE_LOW_CYC
                        - nbx_pkg::CODE_HOLD_CYC;
                end
            end
            nbx_pkg::ST_LOW: begin
                if (cnt_done) begin
                    nxt_state = nbx_pkg::ST_DATA_HOLD; // [RULE3]
                    nxt_cnt = nbx_pkg::DATA_HOLD_CYC;
                end
            end
            nbx_pkg::ST_DATA_HOLD: begin
                if (cnt_done) begin
                    nxt_state = nbx_pkg::ST_RECOVER;
                    nxt_cnt = nbx_pkg::FLOAT_CYC;
                end
            end
            nbx_pkg::ST_RECOVER: begin
                if (cnt_done) begin
                    nxt_state = nbx_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = nbx_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= nbx_pkg::ST_IDLE;
            cnt_ff <= nbx_pkg::CNT_RST;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ready only while idle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= (nxt_state == nbx_pkg::ST_IDLE);
        end
    end

    // command capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_ff <= 1'b0;
            port_ff <= 2'h0;
            op_ff <= nbx_pkg::OP_READ;
            data_ff <= nbx_pkg::NIBBLE_RST;
        end else if (state_ff == nbx_pkg::ST_IDLE && cmd_valid) begin
            unit_ff <= cmd_unit;
            port_ff <= cmd_port;
            op_ff <= cmd_op;
            data_ff <= cmd_data;
        end
    end

    // pin drive values
    always_comb begin
        pif.bus_out = nbx_pkg::NIBBLE_RST;
        pif.bus_oe = 1'b0;
        pif.strobe = 1'b1;
        pif.sel_n = nbx_pkg::SEL_RST;
        if (state_ff != nbx_pkg::ST_IDLE) begin
            pif.sel_n[unit_ff] = 1'b0; // [RULE17] [RULE20]
        end
        case (state_ff)
            nbx_pkg::ST_SETUP, nbx_pkg::ST_CMD_HOLD: begin
                pif.bus_oe = 1'b1;
                pif.bus_out[nbx_pkg::PORT_LSB +: 2] = port_ff; // [RULE4]
                pif.bus_out[nbx_pkg::OP_LSB +: 2] = op_ff; // [RULE4]
                pif.strobe = (state_ff == nbx_pkg::ST_SETUP);
            end
            nbx_pkg::ST_LOW: begin
                pif.strobe = 1'b0;
                pif.bus_oe = !is_read; // [RULE2]
                pif.bus_out = data_ff;
            end
            nbx_pkg::ST_DATA_HOLD: begin
                pif.bus_oe = !is_read;
                pif.bus_out = data_ff;
            end
            nbx_pkg::ST_RECOVER: begin
                // expander may still drive, so the bus stays released
                pif.bus_oe = 1'b0;
                pif.strobe = 1'b1;
            end
            nbx_pkg::ST_IDLE: begin
                // idle: nibble bus left to the pull-ups
                pif.bus_oe = 1'b0;
                pif.bus_out = nbx_pkg::NIBBLE_RST;
            end
            default: begin
                pif.bus_oe = 1'b0;
            end
        endcase
    end

    // read answer sampled just before the rise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= nbx_pkg::NIBBLE_RST;
            rsp_stale <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_ff == nbx_pkg::ST_LOW && cnt_done && is_read) begin
                rsp_valid <= 1'b1;
                rsp_data <= pif.bus_sync;
                rsp_stale <= stale_ff[slot]; // [RULE16]
            end
        end
    end

    // per unit and port: written since last read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stale_ff <= nbx_pkg::STALE_RST;
        end else if (state_ff == nbx_pkg::ST_LOW && cnt_done) begin
            stale_ff[slot] <= !is_read; // [RULE16]
        end
    end
endmodule // nbx_host

/* File: testbench/nbx_host_properties.sv */
`timescale 1ns/100ps
module nbx_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // answer and pins
    input wire logic rsp_valid,
    input wire logic [3:0] nib_out,
    input wire logic nib_oe,
    input wire logic transfer_strobe,
    input wire logic [1:0] unit_sel_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] low_ff;
    // counts strobe low cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            low_ff <= 8'h00;
        else if (transfer_strobe)
            low_ff <= 8'h00;
        else if (low_ff != 8'hFF)
            low_ff <= low_ff + 8'h01;
    end
    sequence s_fall;
        $fell(transfer_strobe);
    endsequence
    sequence s_hold;
        (nib_oe && $stable(nib_out)) [*8];
    endsequence
    property p_sel_low;
        !transfer_strobe |-> unit_sel_n != 2'h3;
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("strobe low without select");
    property p_sel_stable;
        !transfer_strobe |-> $stable(unit_sel_n);
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("select moved while strobe low");
    property p_one_sel;
        unit_sel_n != 2'h0;
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("two expanders selected at once");
    property p_setup;
        s_fall |-> $past(nib_oe, 20) && nib_out == $past(nib_out, 20);
    endproperty
    a_setup: assert property (p_setup)
        else $error("command nibble not set up");
    property p_hold;
        s_fall |-> s_hold;
    endproperty
    a_hold: assert property (p_hold)
        else $error("command nibble not held");
    property p_width;
        $rose(transfer_strobe) |-> low_ff >= 8'hAF;
    endproperty
    a_width: assert property (p_width)
        else $error("strobe low too short");
    property p_read_rel;
        s_fall ##0 (nib_out[3:2] == 2'h0) |-> ##[1:40] !nib_oe;
    endproperty
    a_read_rel: assert property (p_read_rel)
        else $error("bus not released on read");
    property p_data_hold;
        $rose(transfer_strobe) && nib_oe |-> (nib_oe && $stable(nib_out)) [*5];
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data nibble not held");
    property p_rsp;
        rsp_valid |-> ##[1:3] $rose(transfer_strobe);
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("read answer not at strobe rise");
endmodule // nbx_props
bind nbx_host nbx_props nbx_props_i (.core_clk, .rst_n, .rsp_valid,
    .nib_out, .nib_oe, .transfer_strobe, .unit_sel_n);

/* File: testbench/nbx_exp_model.sv */
`timescale 1ns/100ps
module nbx_exp_model #(parameter logic [15:0] EXT = 16'h0000) (
    // pins
    input wire logic strobe,
    input wire logic sel_n,
    input wire logic [3:0] bus,
    // drive
    output logic [3:0] bus_drv = 4'h0,
    output logic bus_en = 1'b0,
    output logic [15:0] port_q = 16'h0000,
    output logic [3:0] port_en = 4'h0
);
    logic [1:0] op, pn;
    logic live = 1'b0;
    always @(negedge strobe) if (!sel_n) begin
        live = 1'b1;
        {op, pn} = bus;
        if (op == 2'h0) begin
            bus_drv = port_en[pn] ? port_q[4*pn+:4] : EXT[4*pn+:4];
            port_en[pn] = 1'b0;
            bus_en <= #80 1'b1;
        end
    end
    always @(posedge strobe) if (!sel_n && live) begin
        bus_en = 1'b0;
        case (op)
            2'h1: port_q[4*pn+:4] = bus;
            2'h2: port_q[4*pn+:4] |= bus;
            2'h3: port_q[4*pn+:4] &= bus;
            default: ;
        endcase
        if (op != 2'h0)
            port_en[pn] = 1'b1;
    end
endmodule // nbx_exp_model

/* File: testbench/test_nbx_host.sv */
`timescale 1ns/100ps
module test_nbx_host;
    localparam logic [15:0] EXT0 = 16'hC3A5;
    localparam logic [15:0] EXT1 = 16'h7E1B;
    logic core_clk = 0, rst_n = 0, cmd_valid = 0, cmd_unit = 0;
    logic [1:0] cmd_port = 2'h0, cmd_op = 2'h0;
    logic [3:0] cmd_data = 4'h0;
    wire logic cmd_ready, rsp_valid, rsp_stale, nib_oe, transfer_strobe;
    wire logic e0, e1;
    wire logic [3:0] rsp_data, nib_out, d0, d1, pe0;
    wire logic [1:0] unit_sel_n;
    wire logic [15:0] q0, q1;
    int mismatches = 0, n_checks = 0;
    // pulled-up shared nibble bus
    wire logic [3:0] nib_in = nib_oe ? nib_out : e0 ? d0 : e1 ? d1 : 4'hF;
    always #2 core_clk = ~core_clk;
    nbx_host nbx_host_i (.core_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_unit,
        .cmd_port, .cmd_op, .cmd_data, .rsp_valid, .rsp_data, .rsp_stale,
        .nib_in, .nib_out, .nib_oe, .transfer_strobe, .unit_sel_n);
    nbx_exp_model #(.EXT(EXT0)) nbx_exp_model_i (.strobe(transfer_strobe),
        .sel_n(unit_sel_n[0]), .bus(nib_in), .bus_drv(d0), .bus_en(e0),
        .port_q(q0), .port_en(pe0));
    nbx_exp_model #(.EXT(EXT1)) nbx_exp_model_b_i (.strobe(transfer_strobe),
        .sel_n(unit_sel_n[1]), .bus(nib_in), .bus_drv(d1), .bus_en(e1),
        .port_q(q1), .port_en());
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_flag(input logic rd);
        for (int i = 0; i < 300; i++) begin
            if ((rd ? rsp_valid : cmd_ready) === 1'b1)
                return;
            @(posedge core_clk) #1;
        end
        mismatches++;
        $display("mismatch at %0t: wait timed out", $time);
        tally_and_finish;
    endtask
    task automatic cmd(input logic u, input logic [1:0] p, o,
            input logic [3:0] d);
        wait_flag(0);
        {cmd_unit, cmd_port, cmd_op, cmd_data} = {u, p, o, d};
        cmd_valid = 1;
        @(posedge core_clk) #1;
        cmd_valid = 0;
        repeat (2) @(posedge core_clk) #1;
        if (o == 2'h0)
            wait_flag(1);
        wait_flag(0);
    endtask
    task automatic t_reset;
        chk(16'({transfer_strobe, unit_sel_n}), 16'h7);
        chk(16'({cmd_ready, nib_oe, nib_out}), 16'h0);
        chk(16'({rsp_valid, rsp_stale, rsp_data}), 16'h0);
        chk(16'({e0, e1, pe0}), 16'h0);
        rst_n = 1;
        @(posedge core_clk) #1;
        chk(16'({cmd_ready, nib_oe}), 16'h2);
        $display("reset test done");
    endtask
    task automatic t_write;
        logic [3:0] e;
        for (int p = 0; p < 4; p++) begin
            e = 4'h5 ^ 4'(p);
            cmd(0, 2'(p), 2'h1, e);
            chk(16'(q0[4*p+:4]), 16'(e));
            cmd(0, 2'(p), 2'h2, 4'hA);
            e = e | 4'hA;
            chk(16'(q0[4*p+:4]), 16'(e));
            cmd(0, 2'(p), 2'h3, 4'h6);
            e = e & 4'h6;
            chk(16'(q0[4*p+:4]), 16'(e));
        end
        chk(16'(pe0), 16'hF);
        chk(q0, 16'h6666);
        $display("write test done");
    endtask
    task automatic t_read;
        for (int p = 0; p < 4; p++) begin
            cmd(0, 2'(p), 2'h0, 4'h0);
            chk(16'({rsp_stale, rsp_data}), {12'h001, q0[4*p+:4]});
            cmd(0, 2'(p), 2'h0, 4'h0);
            chk(16'({rsp_stale, rsp_data}), 16'(EXT0[4*p+:4]));
        end
        chk(16'(pe0), 16'h0);
        $display("read test done");
    endtask
    task automatic t_units;
        logic [15:0] keep;
        keep = q0;
        cmd(1, 2'h2, 2'h1, 4'h9);
        chk(16'(q1[11:8]), 16'h9);
        chk(q0, keep);
        cmd(1, 2'h3, 2'h0, 4'h0);
        chk(16'({rsp_stale, rsp_data}), 16'(EXT1[15:12]));
        $display("unit test done");
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        t_reset;
        t_write;
        t_read;
        t_units;
        tally_and_finish;
    end
endmodule // test_nbx_host
